// ---- tsbi_defines.svh ----
// Constants for the two-wire bus host controller: device register map,
// field positions, control words, own register map and timing counts.
// Assumes a 100 MHz system clock.
`ifndef TSBI_DEFINES_SVH
`define TSBI_DEFINES_SVH

// Device registers, reached through the device's own access port
`define TSBI_DEV_CTRL1_ADDR    16'h0170
`define TSBI_DEV_DBUF_ADDR     16'h0171
`define TSBI_DEV_CTRL2_ADDR    16'h0173
`define TSBI_DEV_STAT_ADDR     16'h0173

// Status register bit positions
`define TSBI_SR_MASTER         7
`define TSBI_SR_TRX            6
`define TSBI_SR_BUSY           5
`define TSBI_SR_PIN            4
`define TSBI_SR_ALOST          3
`define TSBI_SR_AAS            2
`define TSBI_SR_GC             1
`define TSBI_SR_LRB            0

// Control register 2 words: {master_select, transmit, bus_busy, pending_n, mode, 00}
`define TSBI_MODE_TWO_WIRE     2'h2
`define TSBI_CR2_START         8'hF8
`define TSBI_CR2_STOP          8'hD8
`define TSBI_CR2_RESTART       8'h18
`define TSBI_CR2_SLV_PIN       8'h58
`define TSBI_CR2_SLV_REL       8'h18

// Control register 1 layout: word_bit_count in 7:5, acknowledge mode in 4
`define TSBI_CR1_BC_LSB        5
`define TSBI_CR1_ACK           4

// Own register map, byte addresses
`define TSBI_REG_CMD           8'h00
`define TSBI_REG_STAT          8'h04
`define TSBI_REG_TXD           8'h08
`define TSBI_REG_RXD           8'h0C
`define TSBI_REG_BCNT          8'h10

// Own status register bit positions
`define TSBI_ST_BUSY           0
`define TSBI_ST_STOP           1
`define TSBI_ST_XFER           2
`define TSBI_ST_ALOST          3
`define TSBI_ST_RXV            4
`define TSBI_ST_SWAIT          5
`define TSBI_ST_DSR_LSB        8

// Reset values
`define TSBI_TXD_RST           8'h00
`define TSBI_BCNT_RST          3'h0

// Timing
`define TSBI_CLK_PERIOD_NS     10
`define TSBI_RESTART_SETUP_NS  4700
`define TSBI_RESTART_CYC       ((`TSBI_RESTART_SETUP_NS + `TSBI_CLK_PERIOD_NS - 1) / `TSBI_CLK_PERIOD_NS)
`define TSBI_RD_WAIT           3

`endif

// ---- tsbi_pkg.sv ----
// Types shared by the host controller modules.
// Assumes tsbi_defines.svh holds every number.
package tsbi_pkg;
  typedef enum logic [2:0] {
    TSBI_CMD_NONE,
    TSBI_CMD_START,
    TSBI_CMD_STOP,
    TSBI_CMD_RESTART,
    TSBI_CMD_WRITE,
    TSBI_CMD_READ
  } tsbi_cmd_t;

  typedef enum {
    S_IDLE,
    S_START_DB, S_START_CR,
    S_STOP_CR,
    S_RS_CR, S_RS_BUSY, S_RS_LRB, S_RS_WAIT,
    S_IRQ_SR,
    S_SL_BC, S_SL_TX, S_SL_PIN, S_SL_REL, S_SL_DUMMY, S_SL_RBC, S_SL_RD,
    S_WR_BC, S_WR_DB, S_RD_BC, S_RD_DB
  } tsbi_state_t;
endpackage

// ---- tsbi_acc_if.sv ----
// One device register access between the sequencer and the device port.
// Assumes both ends run on the system clock.
interface tsbi_acc_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;

  modport ctl  (output req, output we, output addr, output wdata, input done, input rdata);
  modport port (input req, input we, input addr, input wdata, output done, output rdata);
endinterface

// ---- tsbi_sync.sv ----
// Two-flop synchronisers for inputs arriving from the device pins.
// Assumes each bit is quasi-static or a pulse longer than two clocks.
module tsbi_sync #(
  parameter int W = 10
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_r[g] <= 1'b0;
          o_q[g]    <= 1'b0;
        end else begin
          meta_r[g] <= i_d[g];
          o_q[g]    <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule

// ---- tsbi_devport.sv ----
// Device access port: turns one request into a write or read strobe on the
// device pins. Read data are taken from the synchronised data bus after a
// fixed wait; the device holds them steady after its read strobe.
`include "tsbi_defines.svh"
module tsbi_devport (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  tsbi_acc_if.port        acc,
  input  wire logic [7:0] i_rdata_sync,
  output logic     [15:0] o_dev_addr,
  output logic      [7:0] o_dev_wdata,
  output logic            o_dev_wr,
  output logic            o_dev_rd
);
  logic [1:0] wait_r;
  logic       rd_busy_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dev_addr  <= 16'h0000;
      o_dev_wdata <= 8'h00;
      o_dev_wr    <= 1'b0;
      o_dev_rd    <= 1'b0;
      rd_busy_r   <= 1'b0;
      wait_r      <= 2'h0;
      acc.done    <= 1'b0;
      acc.rdata   <= 8'h00;
    end else begin
      o_dev_wr <= 1'b0;
      o_dev_rd <= 1'b0;
      acc.done <= 1'b0;
      if (acc.req && !rd_busy_r) begin
        o_dev_addr  <= acc.addr;
        o_dev_wdata <= acc.wdata;
        o_dev_wr    <= acc.we;
        o_dev_rd    <= !acc.we;
        acc.done    <= acc.we;
        rd_busy_r   <= !acc.we;
        wait_r      <= 2'(`TSBI_RD_WAIT);
      end else if (rd_busy_r) begin
        if (wait_r == 2'h0) begin
          acc.rdata <= i_rdata_sync;
          acc.done  <= 1'b1;
          rd_busy_r <= 1'b0;
        end else begin
          wait_r <= wait_r - 2'h1;
        end
      end
    end
  end
endmodule

// ---- tsbi_host.sv ----
// Host controller for a two-wire bus interface device: drives its control,
// status and data buffer registers and answers its two interrupts.
// Assumes the device registers sit behind a simple strobe port and that
// its interrupt lines are pulses of at least two system clocks.
`include "tsbi_defines.svh"
module tsbi_host (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESETN,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  output logic      [15:0] O_DEV_ADDR,
  output logic      [7:0]  O_DEV_WDATA,
  output logic             O_DEV_WR,
  output logic             O_DEV_RD,
  input  wire logic [7:0]  I_DEV_RDATA,
  input  wire logic        I_XFER_IRQ,
  input  wire logic        I_STOP_IRQ
);
  tsbi_acc_if acc ();

  tsbi_pkg::tsbi_state_t state_r;
  tsbi_pkg::tsbi_state_t state_nxt;

  logic [9:0]  sync_q;
  logic [7:0]  dev_rdata_sync;
  logic        xfer_lvl;
  logic        stop_lvl;
  logic        xfer_lvl_d_r;
  logic        stop_lvl_d_r;
  logic        xfer_evt;
  logic        stop_evt;
  logic        xfer_pend_r;
  logic [7:0]  txd_r;
  logic [7:0]  rxd_r;
  logic [2:0]  bcnt_r;
  logic [7:0]  dev_sr_r;
  logic        stop_seen_r;
  logic        xfer_seen_r;
  logic        alost_r;
  logic        rxv_r;
  logic        stop_wait_r;
  logic        issue_r;
  logic [9:0]  wait_cnt_r;
  logic        cmd_wr;
  logic        stat_wr;
  logic        busy;
  logic        rx_load;
  logic        acc_is;
  logic        acc_we;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata;
  logic [7:0]  cr1_word;
  tsbi_pkg::tsbi_cmd_t cmd;

  tsbi_sync #(
    .W (10)
  ) u_sync (
    .i_clk    (I_SYS_CLK),
    .i_resetn (I_RESETN),
    .i_d      ({I_STOP_IRQ, I_XFER_IRQ, I_DEV_RDATA}),
    .o_q      (sync_q)
  );

  tsbi_devport u_devport (
    .i_clk        (I_SYS_CLK),
    .i_resetn     (I_RESETN),
    .acc          (acc.port),
    .i_rdata_sync (dev_rdata_sync),
    .o_dev_addr   (O_DEV_ADDR),
    .o_dev_wdata  (O_DEV_WDATA),
    .o_dev_wr     (O_DEV_WR),
    .o_dev_rd     (O_DEV_RD)
  );

  assign dev_rdata_sync = sync_q[7:0];
  assign xfer_lvl       = sync_q[8];
  assign stop_lvl       = sync_q[9];
  assign xfer_evt       = xfer_lvl && !xfer_lvl_d_r;
  assign stop_evt       = stop_lvl && !stop_lvl_d_r;
  assign cmd            = tsbi_pkg::tsbi_cmd_t'(I_WDATA[2:0]);
  assign cmd_wr         = I_WR && (I_ADDR == `TSBI_REG_CMD);
  assign stat_wr        = I_WR && (I_ADDR == `TSBI_REG_STAT);
  assign busy           = (state_r != tsbi_pkg::S_IDLE);
  // Bit count in 7:5, acknowledge mode on, low nibble zero
  assign cr1_word       = {bcnt_r, 1'b1, 4'h0};

  // Interrupt edge detection, fed from the second synchroniser flop
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      xfer_lvl_d_r <= 1'b0;
      stop_lvl_d_r <= 1'b0;
    end else begin
      xfer_lvl_d_r <= xfer_lvl;
      stop_lvl_d_r <= stop_lvl;
    end
  end

  // Access each state makes, and the state that follows its completion
  always_comb begin
    acc_is    = 1'b1;
    acc_we    = 1'b1;
    acc_addr  = `TSBI_DEV_DBUF_ADDR;
    acc_wdata = txd_r;
    state_nxt = tsbi_pkg::S_IDLE;
    rx_load   = 1'b0;
    case (state_r)
      tsbi_pkg::S_START_DB: begin
        state_nxt = tsbi_pkg::S_START_CR;
      end
      tsbi_pkg::S_START_CR: begin
        acc_addr  = `TSBI_DEV_CTRL2_ADDR;
        acc_wdata = `TSBI_CR2_START;
      end
      tsbi_pkg::S_STOP_CR: begin
        acc_addr  = `TSBI_DEV_CTRL2_ADDR;
        acc_wdata = `TSBI_CR2_STOP;
      end
      tsbi_pkg::S_RS_CR: begin
        acc_addr  = `TSBI_DEV_CTRL2_ADDR;
        acc_wdata = `TSBI_CR2_RESTART;
        state_nxt = tsbi_pkg::S_RS_BUSY;
      end
      tsbi_pkg::S_RS_BUSY: begin
        acc_we    = 1'b0;
        acc_addr  = `TSBI_DEV_STAT_ADDR;
        state_nxt = acc.rdata[`TSBI_SR_BUSY] ? tsbi_pkg::S_RS_BUSY
                                             : tsbi_pkg::S_RS_LRB;
      end
      tsbi_pkg::S_RS_LRB: begin
        acc_we    = 1'b0;
        acc_addr  = `TSBI_DEV_STAT_ADDR;
        state_nxt = acc.rdata[`TSBI_SR_LRB] ? tsbi_pkg::S_RS_WAIT
                                            : tsbi_pkg::S_RS_LRB;
      end
      tsbi_pkg::S_IRQ_SR: begin
        acc_we    = 1'b0;
        acc_addr  = `TSBI_DEV_STAT_ADDR;
        // Slave cases decoded from a status read taken after the interrupt
        if (acc.rdata[`TSBI_SR_MASTER]) begin
          state_nxt = tsbi_pkg::S_IDLE;
        end else if (acc.rdata[`TSBI_SR_TRX]) begin
          if (acc.rdata[`TSBI_SR_AAS] || !acc.rdata[`TSBI_SR_LRB]) begin
            state_nxt = tsbi_pkg::S_SL_BC;
          end else begin
            state_nxt = tsbi_pkg::S_SL_PIN;
          end
        end else if (acc.rdata[`TSBI_SR_AAS]) begin
          state_nxt = tsbi_pkg::S_SL_DUMMY;
        end else if (acc.rdata[`TSBI_SR_ALOST]) begin
          state_nxt = tsbi_pkg::S_IDLE;
        end else begin
          state_nxt = tsbi_pkg::S_SL_RBC;
        end
      end
      tsbi_pkg::S_SL_BC, tsbi_pkg::S_WR_BC: begin
        acc_addr  = `TSBI_DEV_CTRL1_ADDR;
        acc_wdata = cr1_word;
        state_nxt = (state_r == tsbi_pkg::S_SL_BC) ? tsbi_pkg::S_SL_TX
                                                   : tsbi_pkg::S_WR_DB;
      end
      tsbi_pkg::S_SL_TX, tsbi_pkg::S_WR_DB: begin
        acc_wdata = txd_r;
      end
      tsbi_pkg::S_SL_PIN: begin
        acc_addr  = `TSBI_DEV_CTRL2_ADDR;
        acc_wdata = `TSBI_CR2_SLV_PIN;
        state_nxt = tsbi_pkg::S_SL_REL;
      end
      tsbi_pkg::S_SL_REL: begin
        acc_addr  = `TSBI_DEV_CTRL2_ADDR;
        acc_wdata = `TSBI_CR2_SLV_REL;
      end
      tsbi_pkg::S_SL_DUMMY: begin
        acc_we = 1'b0;
      end
      tsbi_pkg::S_SL_RBC, tsbi_pkg::S_RD_BC: begin
        acc_addr  = `TSBI_DEV_CTRL1_ADDR;
        acc_wdata = cr1_word;
        state_nxt = (state_r == tsbi_pkg::S_SL_RBC) ? tsbi_pkg::S_SL_RD
                                                    : tsbi_pkg::S_RD_DB;
      end
      tsbi_pkg::S_SL_RD, tsbi_pkg::S_RD_DB: begin
        acc_we  = 1'b0;
        rx_load = 1'b1;
      end
      default: begin
        acc_is    = 1'b0;
        state_nxt = state_r;
      end
    endcase
  end

  // Sequencer: one access per state except S_IDLE and S_RS_WAIT, new request whenever a state other than S_IDLE or S_RS_WAIT is entered
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_r    <= tsbi_pkg::S_IDLE;
      issue_r    <= 1'b0;
      wait_cnt_r <= 10'h000;
      dev_sr_r   <= 8'h00;
      acc.req    <= 1'b0;
      acc.we     <= 1'b0;
      acc.addr   <= 16'h0000;
      acc.wdata  <= 8'h00;
    end else begin
      acc.req <= 1'b0;
      if (issue_r && acc_is) begin
        acc.req   <= 1'b1;
        acc.we    <= acc_we;
        acc.addr  <= acc_addr;
        acc.wdata <= acc_wdata;
        issue_r   <= 1'b0;
      end
      case (state_r)
        tsbi_pkg::S_IDLE: begin
          if (xfer_pend_r || xfer_evt) begin
            state_r <= tsbi_pkg::S_IRQ_SR;
            issue_r <= 1'b1;
          end else if (cmd_wr && !stop_wait_r) begin
            issue_r <= 1'b1;
            case (cmd)
              // A fresh start always runs the whole sequence again
              tsbi_pkg::TSBI_CMD_START:   state_r <= tsbi_pkg::S_START_DB;
              tsbi_pkg::TSBI_CMD_STOP:    state_r <= tsbi_pkg::S_STOP_CR;
              tsbi_pkg::TSBI_CMD_RESTART: state_r <= tsbi_pkg::S_RS_CR;
              tsbi_pkg::TSBI_CMD_WRITE:   state_r <= tsbi_pkg::S_WR_BC;
              tsbi_pkg::TSBI_CMD_READ:    state_r <= tsbi_pkg::S_RD_BC;
              default:                    issue_r <= 1'b0;
            endcase
          end
        end
        tsbi_pkg::S_RS_WAIT: begin
          // Bus-free setup time before the new start
          if (wait_cnt_r == 10'(`TSBI_RESTART_CYC - 1)) begin
            wait_cnt_r <= 10'h000;
            state_r    <= tsbi_pkg::S_START_DB;
            issue_r    <= 1'b1;
          end else begin
            wait_cnt_r <= wait_cnt_r + 10'h001;
          end
        end
        default: begin
          if (acc.done) begin
            state_r <= state_nxt;
            issue_r <= (state_nxt != tsbi_pkg::S_IDLE) &&
                       (state_nxt != tsbi_pkg::S_RS_WAIT);
            if (state_r == tsbi_pkg::S_IRQ_SR) begin
              dev_sr_r <= acc.rdata;
            end
          end
        end
      endcase
    end
  end

  // Transfer interrupt pending until the idle sequencer takes it
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      xfer_pend_r <= 1'b0;
    end else if (xfer_evt && busy) begin
      xfer_pend_r <= 1'b1;
    end else if (state_r == tsbi_pkg::S_IDLE) begin
      xfer_pend_r <= 1'b0;
    end
  end

  // Stop request holds off control writes until the stop interrupt
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      stop_wait_r <= 1'b0;
    end else if (state_r == tsbi_pkg::S_STOP_CR && acc.done) begin
      stop_wait_r <= 1'b1;
    end else if (stop_evt) begin
      stop_wait_r <= 1'b0;
    end
  end

  // Sticky flags: a hardware set wins over a software clear
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      stop_seen_r <= 1'b0;
      xfer_seen_r <= 1'b0;
      alost_r     <= 1'b0;
      rxv_r       <= 1'b0;
    end else begin
      if (stop_evt) begin
        stop_seen_r <= 1'b1;
      end else if (stat_wr && I_WDATA[`TSBI_ST_STOP]) begin
        stop_seen_r <= 1'b0;
      end
      if (xfer_evt) begin
        xfer_seen_r <= 1'b1;
      end else if (stat_wr && I_WDATA[`TSBI_ST_XFER]) begin
        xfer_seen_r <= 1'b0;
      end
      if (state_r == tsbi_pkg::S_IRQ_SR && acc.done && !acc.rdata[`TSBI_SR_MASTER] &&
          !acc.rdata[`TSBI_SR_TRX] && acc.rdata[`TSBI_SR_ALOST] &&
          !acc.rdata[`TSBI_SR_AAS]) begin
        alost_r <= 1'b1;
      end else if (stat_wr && I_WDATA[`TSBI_ST_ALOST]) begin
        alost_r <= 1'b0;
      end
      if (rx_load && acc.done) begin
        rxv_r <= 1'b1;
      end else if (stat_wr && I_WDATA[`TSBI_ST_RXV]) begin
        rxv_r <= 1'b0;
      end
    end
  end

  // Received byte capture
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rxd_r <= 8'h00;
    end else if (rx_load && acc.done) begin
      rxd_r <= acc.rdata;
    end
  end

  // Own writable registers
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      txd_r  <= `TSBI_TXD_RST;
      bcnt_r <= `TSBI_BCNT_RST;
    end else if (I_WR) begin
      if (I_ADDR == `TSBI_REG_TXD) begin
        txd_r <= I_WDATA[7:0];
      end
      if (I_ADDR == `TSBI_REG_BCNT) begin
        bcnt_r <= I_WDATA[2:0];
      end
    end
  end

  // Read data stand in the cycle after the read strobe only
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        `TSBI_REG_STAT: O_RDATA <= {16'h0000, dev_sr_r, 2'b00, stop_wait_r, rxv_r,
                                    alost_r, xfer_seen_r, stop_seen_r, busy};
        `TSBI_REG_TXD:  O_RDATA <= {24'h00_0000, txd_r};
        `TSBI_REG_RXD:  O_RDATA <= {24'h00_0000, rxd_r};
        `TSBI_REG_BCNT: O_RDATA <= {29'h0000_0000, bcnt_r};
        default:        O_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end
endmodule

// ---- tsbi_host_props.sv ----
// Checker for the host controller's device strobes and own read port.
// Bound to every tsbi_host; it sees the top module's ports only.
`include "tsbi_defines.svh"
module tsbi_host_props (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RESETN,
  input wire logic        I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic [15:0] O_DEV_ADDR,
  input wire logic [7:0]  O_DEV_WDATA,
  input wire logic        O_DEV_WR,
  input wire logic        O_DEV_RD,
  input wire logic        I_STOP_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  logic       cr2_wr;
  logic       stop_pend_r;
  logic       rs_r;
  logic       prev58_r;
  logic [9:0] cnt_r;
  assign cr2_wr = O_DEV_WR && O_DEV_ADDR == 16'h0173;
  // A restart is an 18 word not preceded by the slave pending word
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      {stop_pend_r, rs_r, prev58_r, cnt_r} <= '0;
    end else begin
      cnt_r <= (O_DEV_RD && O_DEV_ADDR == 16'h0173) ? 10'h000 : cnt_r + {9'h000, cnt_r != 10'h3FF};
      if (cr2_wr) prev58_r <= O_DEV_WDATA == 8'h58;
      if (cr2_wr && O_DEV_WDATA == 8'h18 && !prev58_r) rs_r <= 1'b1;
      if (cr2_wr && O_DEV_WDATA == 8'hF8) rs_r <= 1'b0;
      if (cr2_wr && O_DEV_WDATA == 8'hD8) stop_pend_r <= 1'b1;
      if (I_STOP_IRQ) stop_pend_r <= 1'b0;
    end
  end
  a_wr_pulse: assert property (O_DEV_WR |=> !O_DEV_WR)
    else $error("device write strobe longer than one cycle");
  a_rd_pulse: assert property (O_DEV_RD |=> !O_DEV_RD)
    else $error("device read strobe longer than one cycle");
  a_rdata_idle: assert property (O_RDATA != 32'h0000_0000 |-> $past(I_RD))
    else $error("read data outside the cycle after a read");
  a_stop_hold: assert property (stop_pend_r |-> !cr2_wr)
    else $error("control word written while stop pending");
  a_mode_bits: assert property (cr2_wr |-> O_DEV_WDATA[3:0] == 4'h8)
    else $error("control word without two-wire mode");
  a_release_order: assert property (cr2_wr && O_DEV_WDATA == 8'h58 |-> ##[1:10] (cr2_wr && O_DEV_WDATA == 8'h18))
    else $error("pending release not followed by transmit clear");
  a_bc_then_buf: assert property (O_DEV_WR && O_DEV_ADDR == 16'h0170 |-> ##[1:10] ((O_DEV_WR || O_DEV_RD) && O_DEV_ADDR == 16'h0171))
    else $error("bit count not followed by data buffer access");
  a_restart_setup: assert property (rs_r && cr2_wr && O_DEV_WDATA == 8'hF8 |-> cnt_r >= `TSBI_RESTART_CYC)
    else $error("start after restart came too early");
endmodule
bind tsbi_host tsbi_host_props u_tsbi_host_props (.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .O_DEV_ADDR(O_DEV_ADDR), .O_DEV_WDATA(O_DEV_WDATA),
  .O_DEV_WR(O_DEV_WR), .O_DEV_RD(O_DEV_RD), .I_STOP_IRQ(I_STOP_IRQ));

// ---- tsbi_dev_model.sv ----
// Behavioural two-wire bus interface device behind the host's strobe port.
// Status bits other than pending come from the bench.
module tsbi_dev_model (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_sts,
  input  wire logic [7:0]  i_rx,
  input  wire logic        i_go_xfer,
  input  wire logic        i_go_stop,
  input  wire logic        i_hold_clk,
  output logic      [7:0]  o_rdata,
  output logic             o_xfer_irq,
  output logic             o_stop_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cr1_r, txd_r, cr2_r, n_cr2_r, n_dbrd_r;
  logic [2:0] hold_r, xc_r, sc_r;
  logic       pin_r, stop_req_r;
  assign o_xfer_irq = xc_r != 3'h0;
  assign o_stop_irq = sc_r != 3'h0;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      {cr1_r, txd_r, cr2_r, n_cr2_r, n_dbrd_r, o_rdata} <= '0;
      {hold_r, xc_r, sc_r, stop_req_r} <= '0;
      pin_r <= 1'b1;
    end else begin
      if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
      if (xc_r != 3'h0) xc_r <= xc_r - 3'h1;
      if (sc_r != 3'h0) sc_r <= sc_r - 3'h1;
      // Released data lines show the inverse so a stale value never passes
      if (hold_r == 3'h1) o_rdata <= ~o_rdata;
      if (i_wr && i_addr == 16'h0170) cr1_r <= i_wdata;
      if (i_wr && i_addr == 16'h0171) begin
        txd_r <= i_wdata;
        pin_r <= 1'b1;
      end
      if (i_wr && i_addr == 16'h0173) begin
        cr2_r   <= i_wdata;
        n_cr2_r <= n_cr2_r + 8'h01;
        if (i_wdata[4]) pin_r <= 1'b1;
        if (i_wdata == 8'hD8) stop_req_r <= 1'b1;
      end
      if (i_rd) begin
        hold_r  <= 3'h6;
        o_rdata <= (i_addr == 16'h0171) ? i_rx : {i_sts[7:5], pin_r, i_sts[3:0]};
      end
      if (i_rd && i_addr == 16'h0171) begin
        n_dbrd_r <= n_dbrd_r + 8'h01;
        pin_r    <= 1'b1;
      end
      if (i_go_xfer) begin
        xc_r <= 3'h3;
        if (!(i_sts[3] && !i_sts[2] && !i_sts[6])) pin_r <= 1'b0;
      end
      if (i_go_stop || (stop_req_r && !i_hold_clk)) begin
        sc_r       <= 3'h3;
        stop_req_r <= 1'b0;
      end
    end
  end
endmodule

// ---- tsbi_host_tb_top.sv ----
// Self-checking bench: own register port driven here, device model behind.
// Assumes the model answers every device strobe at once.
module tsbi_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_SYS_CLK = 1'b0, I_RESETN = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
  logic [7:0]  I_ADDR = 8'h00, sts = 8'h00, rx = 8'h3C, n0, n1;
  logic [31:0] I_WDATA = 32'h0000_0000, O_RDATA, d;
  logic [15:0] O_DEV_ADDR;
  logic [7:0]  O_DEV_WDATA, I_DEV_RDATA;
  logic        O_DEV_WR, O_DEV_RD, I_XFER_IRQ, I_STOP_IRQ;
  logic        go_x = 1'b0, go_s = 1'b0, hold = 1'b0;
  int          errors = 0, n_compared = 0;
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  tsbi_host u_tsbi_host (.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_DEV_ADDR(O_DEV_ADDR),
    .O_DEV_WDATA(O_DEV_WDATA), .O_DEV_WR(O_DEV_WR), .O_DEV_RD(O_DEV_RD),
    .I_DEV_RDATA(I_DEV_RDATA), .I_XFER_IRQ(I_XFER_IRQ), .I_STOP_IRQ(I_STOP_IRQ));
  tsbi_dev_model u_tsbi_dev_model (.i_clk(I_SYS_CLK), .i_resetn(I_RESETN), .i_addr(O_DEV_ADDR),
    .i_wdata(O_DEV_WDATA), .i_wr(O_DEV_WR), .i_rd(O_DEV_RD), .i_sts(sts), .i_rx(rx),
    .i_go_xfer(go_x), .i_go_stop(go_s), .i_hold_clk(hold), .o_rdata(I_DEV_RDATA),
    .o_xfer_irq(I_XFER_IRQ), .o_stop_irq(I_STOP_IRQ));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge I_SYS_CLK);
    I_WR    <= 1'b1;
    I_ADDR  <= a;
    I_WDATA <= v;
    @(posedge I_SYS_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge I_SYS_CLK);
    I_RD   <= 1'b1;
    I_ADDR <= a;
    @(posedge I_SYS_CLK);
    I_RD <= 1'b0;
    #1 d = O_RDATA;
  endtask
  // Interrupts need three cycles to be seen, so busy is polled only after that
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (8) @(posedge I_SYS_CLK);
    rd(8'h04);
    while (d[0] !== 1'b0) begin
      k++;
      if (k > 600) begin
        errors++;
        give_verdict();
      end
      rd(8'h04);
    end
  endtask
  task automatic fire(input logic [7:0] s);
    sts <= s;
    @(posedge I_SYS_CLK);
    go_x <= 1'b1;
    @(posedge I_SYS_CLK);
    go_x <= 1'b0;
    wait_idle();
  endtask
  task automatic t_reset();
    rd(8'h04);
    chk(d, 32'h0000_0000);
    rd(8'h14);
    chk(d, 32'h0000_0000);
    rd(8'h08);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_slave();
    wr(8'h10, 32'h0000_0003);
    wr(8'h08, 32'h0000_005A);
    n0 = u_tsbi_dev_model.n_dbrd_r;
    n1 = u_tsbi_dev_model.n_cr2_r;
    fire(8'h4C);
    chk(u_tsbi_dev_model.txd_r, 32'h0000_005A);
    chk(u_tsbi_dev_model.cr1_r, 32'h0000_0070);
    wr(8'h08, 32'h0000_0066);
    fire(8'h40);
    chk(u_tsbi_dev_model.txd_r, 32'h0000_0066);
    fire(8'h41);
    chk(u_tsbi_dev_model.n_cr2_r, n1 + 8'h02);
    chk(u_tsbi_dev_model.cr2_r, 32'h0000_0018);
    fire(8'h06);
    chk(u_tsbi_dev_model.n_dbrd_r, n0 + 8'h01);
    chk(d & 32'h0000_FF04, 32'h0000_0604);
    fire(8'h08);
    chk(d & 32'h0000_FF08, 32'h0000_1808);
    chk(u_tsbi_dev_model.n_dbrd_r, n0 + 8'h01);
    fire(8'h00);
    chk(d & 32'h0000_0010, 32'h0000_0010);
    rd(8'h0C);
    chk(d, 32'h0000_003C);
    wr(8'h04, 32'h0000_001E);
  endtask
  task automatic t_start();
    wr(8'h08, 32'h0000_00A5);
    wr(8'h00, 32'h0000_0001);
    wait_idle();
    chk(u_tsbi_dev_model.txd_r, 32'h0000_00A5);
    chk(u_tsbi_dev_model.cr2_r, 32'h0000_00F8);
  endtask
  task automatic t_stop();
    hold <= 1'b1;
    wr(8'h00, 32'h0000_0002);
    repeat (20) @(posedge I_SYS_CLK);
    chk(u_tsbi_dev_model.cr2_r, 32'h0000_00D8);
    n1 = u_tsbi_dev_model.n_cr2_r;
    rd(8'h04);
    chk(d & 32'h0000_0022, 32'h0000_0020);
    wr(8'h00, 32'h0000_0001);
    repeat (20) @(posedge I_SYS_CLK);
    chk(u_tsbi_dev_model.n_cr2_r, n1);
    hold <= 1'b0;
    repeat (20) @(posedge I_SYS_CLK);
    rd(8'h04);
    chk(d & 32'h0000_0022, 32'h0000_0002);
    wr(8'h04, 32'h0000_001E);
    go_s <= 1'b1;
    @(posedge I_SYS_CLK);
    go_s <= 1'b0;
    repeat (10) @(posedge I_SYS_CLK);
    rd(8'h04);
    chk(d & 32'h0000_0002, 32'h0000_0002);
    wr(8'h04, 32'h0000_001E);
  endtask
  task automatic t_restart();
    sts <= 8'h20;
    wr(8'h00, 32'h0000_0003);
    repeat (30) @(posedge I_SYS_CLK);
    chk(u_tsbi_dev_model.cr2_r, 32'h0000_0018);
    sts <= 8'h00;
    repeat (30) @(posedge I_SYS_CLK);
    chk(u_tsbi_dev_model.cr2_r, 32'h0000_0018);
    sts <= 8'h01;
    wait_idle();
    chk(u_tsbi_dev_model.cr2_r, 32'h0000_00F8);
    rd(8'h04);
    chk(d & 32'h0000_0002, 32'h0000_0000);
  endtask
  initial begin
    repeat (6) @(posedge I_SYS_CLK);
    I_RESETN <= 1'b1;
    @(posedge I_SYS_CLK);
    t_reset();
    t_slave();
    t_start();
    t_stop();
    t_restart();
    give_verdict();
  end
endmodule
